/* File: shared/synth_ctrl_pkg.sv */
package synth_ctrl_pkg;

   // ***********************************************************
   // Serial word and latch selection
   // ***********************************************************
   localparam int WORD_W = 32;
   localparam int SEL_W = 3;
   localparam int NUM_LATCH = 6;
   localparam logic [2:0] SEL_L0 = 3'h0;
   localparam logic [2:0] SEL_L1 = 3'h1;
   localparam logic [2:0] SEL_L2 = 3'h2;
   localparam logic [2:0] SEL_L4 = 3'h4;
   localparam logic [2:0] SEL_LAST = 3'h5;
   localparam logic [31:0] LATCH_RST = 32'h0;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int FRAC_LSB = 3;
   localparam int INT_LSB = 15;
   localparam int MOD_LSB = 3;
   localparam int PHASE_LSB = 15;
   localparam int PRESC_BIT = 27;
   localparam int CRST_BIT = 3;
   localparam int CP3_BIT = 4;
   localparam int PD_BIT = 5;
   localparam int LDF_BIT = 8;
   localparam int CPCUR_LSB = 9;
   localparam int DBUF_BIT = 13;
   localparam int RCNT_LSB = 14;
   localparam int RHALF_BIT = 24;
   localparam int RDBL_BIT = 25;
   localparam int MUX_LSB = 26;
   localparam int OPWR_LSB = 3;
   localparam int RFEN_BIT = 5;
   localparam int APWR_LSB = 6;
   localparam int AEN_BIT = 8;
   localparam int ASEL_BIT = 9;
   localparam int MUTE_UNTIL_LOCKED_BIT = 10;
   localparam int VCOPD_BIT = 11;
   localparam int BSDIV_LSB = 12;
   localparam int DIVSEL_LSB = 20;
   localparam int FBSEL_BIT = 23;

   // ***********************************************************
   // Pin indices and counts
   // ***********************************************************
   localparam int NUM_PINS = 8;
   localparam int PIN_SCLK = 0;
   localparam int PIN_SDATA = 1;
   localparam int PIN_LOAD = 2;
   localparam int PIN_REF = 3;
   localparam int PIN_CE = 4;
   localparam int PIN_MUTE = 5;
   localparam int PIN_FB = 6;
   localparam int PIN_LOCK = 7;
   localparam int BAND_CYCLES = 10;

   localparam logic [2:0] MUX_LOW = 3'h0;
   localparam logic [2:0] MUX_HIGH = 3'h1;
   localparam logic [2:0] MUX_RDIV = 3'h3;
   localparam logic [2:0] MUX_NDIV = 3'h4;
   localparam logic [2:0] MUX_ALOCK = 3'h5;
   localparam logic [2:0] MUX_DLOCK = 3'h6;

   typedef enum logic [1:0] {BS_IDLE = 2'b01, BS_RUN = 2'b10} bs_state_t;

   typedef struct packed {
      logic [15:0] int_value;
      logic [11:0] frac_value;
      logic [11:0] fraction_modulus;
      logic [11:0] phase_value;
      logic prescaler_89;
      logic [9:0] r_count;
      logic ref_doubler;
      logic ref_halve;
      logic [3:0] cp_current;
      logic lock_detect_function;
      logic double_buffer_divsel;
      logic power_down;
      logic cp_tristate;
      logic counter_reset;
      logic [2:0] mux_select;
      logic [2:0] divider_select;
      logic feedback_source_select;
      logic [7:0] band_select_clock_div;
      logic vco_power_down;
      logic mute_until_locked;
      logic aux_select;
      logic aux_enable;
      logic [1:0] aux_power;
      logic rf_enable;
      logic [1:0] output_power;
   } synth_cfg_t;

endpackage

/* File: src/synth_serial_program_control.sv */
`timescale 1ns/1ps
module synth_serial_program_control
   import synth_ctrl_pkg::*;
#(
   parameter int BAND_CYCLE_COUNT = BAND_CYCLES
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic reference_input,
   input wire logic chip_enable,
   input wire logic output_mute_pin,
   input wire logic feedback_pulse,
   input wire logic lock_detect_in,
   output synth_cfg_t cfg,
   output logic integer_mode,
   output logic pfd_tick,
   output logic band_select_busy,
   output logic tune_hold,
   output logic device_powered,
   output logic cp_three_state,
   output logic rf_out_on,
   output logic aux_out_on,
   output logic lock_indicator_pin,
   output logic test_mux_output
);

   // The band cycle counter is four bits wide.
   if (BAND_CYCLE_COUNT < 1 || BAND_CYCLE_COUNT > 15)
   begin : bad_band_cycle_count
      $error("BAND_CYCLE_COUNT must lie between 1 and 15.");
   end

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [NUM_PINS-1:0] sync1;
      logic [NUM_PINS-1:0] sync2;
      logic [NUM_PINS-1:0] sync3;
      logic [NUM_PINS-1:0] filt;
      logic [WORD_W-1:0] shift;
      logic [NUM_LATCH-1:0][WORD_W-1:0] latch;
      logic [11:0] buf_mod;
      logic [11:0] buf_phase;
      logic [9:0] buf_rcnt;
      logic buf_dbl;
      logic buf_half;
      logic [3:0] buf_cp;
      logic [2:0] buf_divsel;
      synth_cfg_t cfg;
      logic [9:0] ref_cnt;
      logic half_tgl;
      logic tick;
      logic [7:0] bs_cnt;
      logic [3:0] band_cnt;
      bs_state_t bs;
      logic powered;
      logic cp3;
      logic rf_on;
      logic aux_on;
      logic intn;
      logic lock;
      logic mux;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   logic [NUM_PINS-1:0] pins;
   logic [NUM_PINS-1:0] rise;
   logic [NUM_PINS-1:0] fall;
   logic [2:0] sel;
   logic commit;
   logic ref_ev;
   logic rdiv_ev;
   logic [9:0] r_max;
   logic [7:0] bs_max;
   logic start_bs;

   assign pins = {lock_detect_in, feedback_pulse, output_mute_pin, chip_enable,
                  reference_input, load_strobe, serial_data, serial_clock};

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb
   begin
      s_nxt = s_r;
      rise = '0;
      fall = '0;
      s_nxt.sync1 = pins;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      // A pin level is accepted only once the second and third stages agree.
      for (int i = 0; i < NUM_PINS; i++)
      begin
         if (s_r.sync2[i] == s_r.sync3[i])
         begin
            s_nxt.filt[i] = s_r.sync3[i];
            rise[i] = s_r.sync3[i] & ~s_r.filt[i];
            fall[i] = ~s_r.sync3[i] & s_r.filt[i];
         end
      end

      if (rise[PIN_SCLK])
      begin
         s_nxt.shift = {s_r.shift[WORD_W-2:0], s_nxt.filt[PIN_SDATA]};
      end

      sel = s_r.shift[SEL_W-1:0];
      commit = 1'b0;
      if (rise[PIN_LOAD] && sel <= SEL_LAST)
      begin
         s_nxt.latch[sel] = s_r.shift;
         commit = (sel == SEL_L0);
      end

      if (commit)
      begin
         s_nxt.buf_mod = s_r.latch[SEL_L1][MOD_LSB +: 12];
         s_nxt.buf_phase = s_r.latch[SEL_L1][PHASE_LSB +: 12];
         s_nxt.buf_rcnt = s_r.latch[SEL_L2][RCNT_LSB +: 10];
         s_nxt.buf_dbl = s_r.latch[SEL_L2][RDBL_BIT];
         s_nxt.buf_half = s_r.latch[SEL_L2][RHALF_BIT];
         s_nxt.buf_cp = s_r.latch[SEL_L2][CPCUR_LSB +: 4];
         s_nxt.buf_divsel = s_r.latch[SEL_L4][DIVSEL_LSB +: 3];
      end

      s_nxt.cfg.int_value = s_nxt.latch[SEL_L0][INT_LSB +: 16];
      s_nxt.cfg.frac_value = s_nxt.latch[SEL_L0][FRAC_LSB +: 12];
      s_nxt.cfg.fraction_modulus = s_nxt.buf_mod;
      s_nxt.cfg.phase_value = s_nxt.buf_phase;
      s_nxt.cfg.prescaler_89 = s_nxt.latch[SEL_L1][PRESC_BIT];
      s_nxt.cfg.r_count = s_nxt.buf_rcnt;
      s_nxt.cfg.ref_doubler = s_nxt.buf_dbl;
      s_nxt.cfg.ref_halve = s_nxt.buf_half;
      s_nxt.cfg.cp_current = s_nxt.buf_cp;
      s_nxt.cfg.lock_detect_function = s_nxt.latch[SEL_L2][LDF_BIT];
      s_nxt.cfg.double_buffer_divsel = s_nxt.latch[SEL_L2][DBUF_BIT];
      s_nxt.cfg.power_down = s_nxt.latch[SEL_L2][PD_BIT];
      s_nxt.cfg.cp_tristate = s_nxt.latch[SEL_L2][CP3_BIT];
      s_nxt.cfg.counter_reset = s_nxt.latch[SEL_L2][CRST_BIT];
      s_nxt.cfg.mux_select = s_nxt.latch[SEL_L2][MUX_LSB +: 3];
      s_nxt.cfg.divider_select = s_nxt.cfg.double_buffer_divsel ?
                                 s_nxt.buf_divsel :
                                 s_nxt.latch[SEL_L4][DIVSEL_LSB +: 3];
      s_nxt.cfg.feedback_source_select = s_nxt.latch[SEL_L4][FBSEL_BIT];
      s_nxt.cfg.band_select_clock_div = s_nxt.latch[SEL_L4][BSDIV_LSB +: 8];
      s_nxt.cfg.vco_power_down = s_nxt.latch[SEL_L4][VCOPD_BIT];
      s_nxt.cfg.mute_until_locked = s_nxt.latch[SEL_L4][MUTE_UNTIL_LOCKED_BIT];
      s_nxt.cfg.aux_select = s_nxt.latch[SEL_L4][ASEL_BIT];
      s_nxt.cfg.aux_enable = s_nxt.latch[SEL_L4][AEN_BIT];
      s_nxt.cfg.aux_power = s_nxt.latch[SEL_L4][APWR_LSB +: 2];
      s_nxt.cfg.rf_enable = s_nxt.latch[SEL_L4][RFEN_BIT];
      s_nxt.cfg.output_power = s_nxt.latch[SEL_L4][OPWR_LSB +: 2];

      // Reference path: doubler counts both edges, halving drops every other output.
      s_nxt.powered = s_nxt.filt[PIN_CE] & ~s_nxt.cfg.power_down;
      ref_ev = rise[PIN_REF] | (s_r.cfg.ref_doubler & fall[PIN_REF]);
      r_max = (s_r.cfg.r_count == 10'h000) ? 10'h001 : s_r.cfg.r_count;
      rdiv_ev = 1'b0;
      s_nxt.tick = 1'b0;
      if (!s_r.powered || s_r.cfg.counter_reset)
      begin
         s_nxt.ref_cnt = '0;
         s_nxt.half_tgl = 1'b0;
      end
      else if (ref_ev)
      begin
         if (s_r.ref_cnt >= r_max - 10'h001)
         begin
            s_nxt.ref_cnt = '0;
            rdiv_ev = 1'b1;
         end
         else
         begin
            s_nxt.ref_cnt = s_r.ref_cnt + 10'h001;
         end
      end
      if (rdiv_ev)
      begin
         s_nxt.half_tgl = ~s_r.half_tgl;
         s_nxt.tick = ~s_r.cfg.ref_halve | s_r.half_tgl;
      end

      // Band selection runs from reset, chip enable rise and each latch 0 write.
      start_bs = commit | rise[PIN_CE];
      bs_max = (s_r.cfg.band_select_clock_div == 8'h00) ? 8'h01 :
               s_r.cfg.band_select_clock_div;
      case (s_r.bs)
         BS_IDLE:
         begin
            if (start_bs)
            begin
               s_nxt.bs = BS_RUN;
               s_nxt.bs_cnt = '0;
               s_nxt.band_cnt = '0;
            end
         end
         BS_RUN:
         begin
            if (start_bs)
            begin
               s_nxt.bs_cnt = '0;
               s_nxt.band_cnt = '0;
            end
            else if (s_r.tick)
            begin
               if (s_r.bs_cnt >= bs_max - 8'h01)
               begin
                  s_nxt.bs_cnt = '0;
                  s_nxt.band_cnt = s_r.band_cnt + 4'h1;
                  if (s_r.band_cnt == 4'(BAND_CYCLE_COUNT - 1))
                  begin
                     s_nxt.bs = BS_IDLE;
                  end
               end
               else
               begin
                  s_nxt.bs_cnt = s_r.bs_cnt + 8'h01;
               end
            end
         end
         default:
         begin
            s_nxt.bs = BS_IDLE;
         end
      endcase

      // Output controls.
      s_nxt.lock = s_nxt.filt[PIN_LOCK];
      s_nxt.cp3 = ~s_nxt.powered | s_nxt.cfg.cp_tristate;
      s_nxt.intn = (s_nxt.cfg.frac_value == 12'h000) &
                   s_nxt.cfg.lock_detect_function;
      s_nxt.rf_on = s_nxt.powered & s_nxt.filt[PIN_MUTE] & s_nxt.cfg.rf_enable &
                    ~s_nxt.cfg.vco_power_down &
                    ~(s_nxt.cfg.mute_until_locked & ~s_nxt.lock);
      s_nxt.aux_on = s_nxt.powered & s_nxt.filt[PIN_MUTE] & s_nxt.cfg.aux_enable &
                     ~s_nxt.cfg.vco_power_down &
                     ~(s_nxt.cfg.mute_until_locked & ~s_nxt.lock);
      case (s_nxt.cfg.mux_select)
         MUX_LOW: s_nxt.mux = 1'b0;
         MUX_HIGH: s_nxt.mux = 1'b1;
         MUX_RDIV: s_nxt.mux = s_nxt.half_tgl;
         MUX_NDIV: s_nxt.mux = s_nxt.filt[PIN_FB];
         MUX_ALOCK: s_nxt.mux = s_nxt.lock;
         MUX_DLOCK: s_nxt.mux = s_nxt.lock;
         default: s_nxt.mux = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.bs <= BS_RUN;
         s_r.cp3 <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign cfg = s_r.cfg;
   assign integer_mode = s_r.intn;
   assign pfd_tick = s_r.tick;
   assign band_select_busy = (s_r.bs == BS_RUN);
   assign tune_hold = (s_r.bs == BS_RUN);
   assign device_powered = s_r.powered;
   assign cp_three_state = s_r.cp3;
   assign rf_out_on = s_r.rf_on;
   assign aux_out_on = s_r.aux_on;
   assign lock_indicator_pin = s_r.lock;
   assign test_mux_output = s_r.mux;

   // ***********************************************************
   // Checks
   // ***********************************************************
   AST_SHIFT: assert property (@(posedge clk) disable iff (!resetn)
      rise[PIN_SCLK] |=> s_r.shift == {$past(s_r.shift[WORD_W-2:0]), $past(s_nxt.filt[PIN_SDATA])})
      else $error("Shift register did not take the data bit.");

   AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !rise[PIN_LOAD] |=> $stable(s_r.latch))
      else $error("Latch changed without a load strobe.");

   AST_LATCH_ONE: assert property (@(posedge clk) disable iff (!resetn)
      rise[PIN_LOAD] && sel == SEL_L1 |=> s_r.latch[1] == $past(s_r.shift)
         && s_r.latch[2] == $past(s_r.latch[2]))
      else $error("Latch 1 load went wrong.");

   AST_UNDEF_CODE: assert property (@(posedge clk) disable iff (!resetn)
      rise[PIN_LOAD] && sel[2:1] == 2'b11 |=> $stable(s_r.latch))
      else $error("Undefined select code changed a latch.");

   AST_DBUF: assert property (@(posedge clk) disable iff (!resetn)
      !commit |=> $stable(s_r.cfg.fraction_modulus) && $stable(s_r.cfg.r_count))
      else $error("Buffered setting changed without latch 0 write.");

   AST_DIVSEL_NOW: assert property (@(posedge clk) disable iff (!resetn)
      rise[PIN_LOAD] && sel == SEL_L4 && !s_r.latch[2][DBUF_BIT]
      |=> s_r.cfg.divider_select == $past(s_r.shift[DIVSEL_LSB +: 3]))
      else $error("Divider select did not apply at once.");

   AST_INTN: assert property (@(posedge clk) disable iff (!resetn)
      integer_mode == (s_r.latch[0][FRAC_LSB +: 12] == 12'h000 && s_r.latch[2][LDF_BIT]))
      else $error("Integer mode flag wrong.");

   AST_BAND_START: assert property (@(posedge clk) disable iff (!resetn)
      commit |=> band_select_busy && s_r.band_cnt == 4'h0)
      else $error("Band selection did not restart on latch 0 write.");

   AST_MUTE_UNTIL_LOCKED: assert property (@(posedge clk) disable iff (!resetn)
      s_r.cfg.mute_until_locked && !lock_indicator_pin |-> !rf_out_on)
      else $error("Output on before lock with mute until locked.");

   AST_MUTE_PIN: assert property (@(posedge clk) disable iff (!resetn)
      !s_r.filt[PIN_MUTE] |-> !rf_out_on && !aux_out_on)
      else $error("Output on while mute pin low.");

   AST_CE: assert property (@(posedge clk) disable iff (!resetn)
      !s_r.filt[PIN_CE] |-> cp_three_state && !device_powered)
      else $error("Pump driven while chip enable low.");

endmodule

/* File: tb/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model
(
   input wire logic clk,
   output logic serial_clock,
   output logic serial_data,
   output logic load_strobe
);
   initial
   begin
      serial_clock = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end

   // *****
   // Word transfer
   // *****
   // The data line has no pull, so between frames it shows the inverse of the last bit.
   task automatic write_word(input logic [31:0] word, input int hold_cyc);
      for (int i = 31; i >= 0; i--)
      begin
         @(negedge clk);
         serial_data = word[i];
         repeat (hold_cyc) @(negedge clk);
         serial_clock = 1'b1;
         repeat (hold_cyc) @(negedge clk);
         serial_clock = 1'b0;
      end
      repeat (hold_cyc) @(negedge clk);
      load_strobe = 1'b1;
      repeat (hold_cyc) @(negedge clk);
      load_strobe = 1'b0;
      serial_data = ~word[0];
   endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import synth_ctrl_pkg::*;
   localparam int BC = 3;
   typedef struct {logic [31:0] w; int fa; logic [15:0] ea; int fb; logic [15:0] eb;} row_t;
   logic clk, resetn, serial_clock, serial_data, load_strobe, reference_input, chip_enable;
   logic output_mute_pin, feedback_pulse, lock_detect_in, integer_mode, pfd_tick;
   logic band_select_busy, tune_hold, device_powered, cp_three_state, rf_out_on;
   logic aux_out_on, lock_indicator_pin, test_mux_output;
   synth_cfg_t cfg;
   int miscompares = 0;
   int n_compared = 0;
   int band_ticks = 0;
   int hold_err = 0;
   int gap;
   logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
   logic exp_mux [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   // The first six rows write latches 5 down to 0 so buffered values land on the latch 0 write.
   row_t rows [13] = '{
      '{32'h00180005, 0, 16'h0, 1, 16'h0},
      '{32'h00302034, 4, 16'h2, 5, 16'h3},
      '{32'h00000003, 0, 16'h0, 7, 16'h2},
      '{32'h0C014102, 3, 16'h0, 8, 16'h3},
      '{32'h00000039, 2, 16'h0, 3, 16'h0},
      '{32'h00320000, 3, 16'h5, 2, 16'h7},
      '{32'h00320000, 0, 16'h64, 6, 16'h1},
      '{32'hFFFFFFFE, 0, 16'h64, 1, 16'h0},
      '{32'hFFFFFFFF, 0, 16'h64, 8, 16'h3},
      '{32'h0C016102, 3, 16'h5, 8, 16'h3},
      '{32'h00502034, 5, 16'h3, 4, 16'h2},
      '{32'h00320018, 5, 16'h5, 6, 16'h0},
      '{32'h00D02034, 9, 16'h1, 1, 16'h3}
   };

   synth_serial_program_control #(.BAND_CYCLE_COUNT(BC)) synth_serial_program_control_i
   (
      .clk(clk), .resetn(resetn), .serial_clock(serial_clock), .serial_data(serial_data),
      .load_strobe(load_strobe), .reference_input(reference_input),
      .chip_enable(chip_enable), .output_mute_pin(output_mute_pin),
      .feedback_pulse(feedback_pulse), .lock_detect_in(lock_detect_in), .cfg(cfg),
      .integer_mode(integer_mode), .pfd_tick(pfd_tick), .band_select_busy(band_select_busy),
      .tune_hold(tune_hold), .device_powered(device_powered),
      .cp_three_state(cp_three_state), .rf_out_on(rf_out_on), .aux_out_on(aux_out_on),
      .lock_indicator_pin(lock_indicator_pin), .test_mux_output(test_mux_output)
   );

   serial_host_model serial_host_model_i
   (
      .clk(clk), .serial_clock(serial_clock), .serial_data(serial_data),
      .load_strobe(load_strobe)
   );

   // *****
   // Clocks and monitors
   // *****
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      reference_input = 1'b0;
      forever
      begin
         repeat (4) @(negedge clk);
         reference_input = ~reference_input;
      end
   end

   always @(negedge clk)
   begin
      if (resetn === 1'b1 && band_select_busy === 1'b1 && pfd_tick === 1'b1)
         band_ticks++;
      if (resetn === 1'b1 && tune_hold !== band_select_busy)
         hold_err++;
   end

   initial
   begin
      #(20 * 60000);
      miscompares++;
      $display("watchdog expired");
      give_verdict();
   end

   // *****
   // Helpers
   // *****
   function automatic logic [15:0] pick(input int f);
      case (f)
         0: pick = cfg.int_value;
         1: pick = {4'h0, cfg.frac_value};
         2: pick = {4'h0, cfg.fraction_modulus};
         3: pick = {6'h0, cfg.r_count};
         4: pick = {14'h0, cfg.output_power};
         5: pick = {13'h0, cfg.divider_select};
         6: pick = {15'h0, integer_mode};
         7: pick = {8'h0, cfg.band_select_clock_div};
         8: pick = {13'h0, cfg.mux_select};
         default: pick = {15'h0, cfg.feedback_source_select};
      endcase
   endfunction

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [31:0] w);
      serial_host_model_i.write_word(w, 4);
      repeat (8) @(negedge clk);
   endtask

   task automatic wait_busy(input logic lvl);
      for (int n = 0; n < 3000 && band_select_busy !== lvl; n++)
         @(negedge clk);
   endtask

   task automatic tick_gap(output int g);
      int n;
      n = 0;
      g = 0;
      while (pfd_tick !== 1'b1 && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      while (pfd_tick !== 1'b1 && g < 4000)
      begin
         @(negedge clk);
         g++;
      end
      g++;
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // *****
   // Test sequence
   // *****
   initial
   begin
      resetn = 1'b0;
      chip_enable = 1'b1;
      output_mute_pin = 1'b1;
      feedback_pulse = 1'b1;
      lock_detect_in = 1'b0;
      repeat (5) @(negedge clk);
      check("busy_in_reset", 16'h1, {15'h0, band_select_busy});
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      check("cfg_zero", 16'h1, {15'h0, cfg === '0});
      check("powered", 16'h1, {15'h0, device_powered});
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(rows[i].w);
         check("field_a", rows[i].ea, pick(rows[i].fa));
         check("field_b", rows[i].eb, pick(rows[i].fb));
         $display("test row %0d done", i);
      end
      wait_busy(1'b0);
      band_ticks = 0;
      serial_host_model_i.write_word(32'h00320018, 6);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("band_ticks", 16'(BC * 2), 16'(band_ticks));
      check("tune_hold", 16'h0, 16'(hold_err));
      $display("test band done");
      for (int k = 0; k < 3; k++)
      begin
         wr(32'h0C016102 | (32'(k == 1) << 25) | (32'(k == 2) << 24));
         wr(32'h00320018);
         tick_gap(gap);
         tick_gap(gap);
         check("pfd_gap", (k == 1) ? 16'd20 : (k == 2) ? 16'd80 : 16'd40, 16'(gap));
      end
      $display("test pfd done");
      for (int k = 0; k < 4; k++)
      begin
         wr(32'h00016102 | (32'(codes[k]) << 26));
         check("mux", {15'h0, exp_mux[k]}, {15'h0, test_mux_output});
      end
      $display("test mux done");
      wr(32'h00D02534);
      check("rf_mute_until_locked", 16'h0, {15'h0, rf_out_on});
      check("aux_on", 16'h0, {15'h0, aux_out_on});
      lock_detect_in = 1'b1;
      repeat (8) @(negedge clk);
      check("rf_locked", 16'h1, {15'h0, rf_out_on});
      check("aux_locked", 16'h1, {15'h0, aux_out_on});
      check("lock_pin", 16'h1, {15'h0, lock_indicator_pin});
      wr(32'h00016102 | (32'(MUX_ALOCK) << 26));
      check("mux_lock", 16'h1, {15'h0, test_mux_output});
      output_mute_pin = 1'b0;
      repeat (8) @(negedge clk);
      check("rf_mute", 16'h0, {15'h0, rf_out_on});
      check("aux_mute", 16'h0, {15'h0, aux_out_on});
      output_mute_pin = 1'b1;
      wr(32'h00D02034);
      check("rf_back", 16'h1, {15'h0, rf_out_on});
      check("aux_off", 16'h0, {15'h0, aux_out_on});
      chip_enable = 1'b0;
      repeat (8) @(negedge clk);
      check("ce_power", 16'h0, {15'h0, device_powered});
      check("ce_pump", 16'h1, {15'h0, cp_three_state});
      chip_enable = 1'b1;
      $display("test outputs done");
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      check("rst_cfg", 16'h1, {15'h0, cfg === '0});
      check("rst_pump", 16'h1, {15'h0, cp_three_state});
      check("rst_busy", 16'h1, {15'h0, band_select_busy});
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      check("rst_powered", 16'h1, {15'h0, device_powered});
      check("rst_pump_on", 16'h0, {15'h0, cp_three_state});
      $display("test second reset done");
      give_verdict();
   end
endmodule
